// File: design/bcps_pkg.sv
package bcps_pkg;
  // clock and time base
  localparam longint CLK_HZ      = 10_000_000;
  localparam longint MS_PER_S    = 1000;
  localparam longint MS_CYC_D    = CLK_HZ / MS_PER_S;
  localparam longint SOFT_MIN    = 5;
  localparam longint QUAL_MIN    = 1;
  localparam longint MS_PER_MIN  = 60_000;
  localparam logic [31:0] SOFT_MS  = 32'(SOFT_MIN * MS_PER_MIN);
  localparam logic [31:0] QUAL_MS  = 32'(QUAL_MIN * MS_PER_MIN);
  localparam longint BEEP_MS     = 200;
  localparam logic [31:0] BEEP_MS_W = 32'(BEEP_MS);
  // pwm: 256 steps per period
  localparam longint PWM_STEPS   = 256;
  localparam longint FAST_PWM_HZ = 250;
  localparam longint SLOW_PWM_DHZ = 1;
  localparam logic [31:0] FAST_TICK_CYC = 32'(CLK_HZ / FAST_PWM_HZ / PWM_STEPS);
  localparam longint SLOW_TICK_D = CLK_HZ * 10 / SLOW_PWM_DHZ / PWM_STEPS;
  // timeout measurement: count in 10 us units
  localparam longint MEAS_US     = 10;
  localparam logic [31:0] MEAS_TICK_CYC = 32'(CLK_HZ / 1_000_000 * MEAS_US);
  localparam logic [31:0] CAP_DISCH_MS  = 32'd5;
  localparam logic [11:0] MEAS_MAX      = 12'hfff;
  localparam longint TO_BASE_MIN = 75;
  localparam logic [31:0] TO_BASE_MS    = 32'(TO_BASE_MIN * MS_PER_MIN);
  localparam logic [31:0] TO_MS_PER_CNT = 32'd27900;
  localparam int     TOP_SHIFT   = 2;
  // sensed comparator bits
  localparam int SN_PRESENT  = 0;
  localparam int SN_GOOD     = 1;
  localparam int SN_NI_MAX   = 2;
  localparam int SN_LI_41    = 3;
  localparam int SN_LI_42    = 4;
  localparam int SN_RESTART  = 5;
  localparam int SN_DROP_CD  = 6;
  localparam int SN_DROP_MH  = 7;
  localparam int SN_CS_LOW   = 8;
  localparam int SN_TEMP_OK  = 9;
  localparam int SN_TEMP_HOT = 10;
  localparam int SN_DISCHGD  = 11;
  localparam int SENSE_W     = 12;
  // synchroniser vector layout
  localparam int SY_DISCHARGE_MAINT_SELECT = 12;
  localparam int SY_BATTERY_TYPE_SELECT = 14;
  localparam int SY_SUPPLY_OR_CELL_SELECT = 16;
  localparam int SY_TOP  = 17;
  localparam int SYNC_W  = 18;
  // tri-level codes
  localparam logic [1:0] TRI_LOW  = 2'h0;
  localparam logic [1:0] TRI_HIGH = 2'h1;
  localparam logic [1:0] TRI_OPEN = 2'h2;
  // register port
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_DUTY   = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_CONFIG = 2'h3;
  localparam int         CTRL_RESTART = 0;
  localparam int         CTRL_TEMPCHK = 1;
  localparam logic [7:0] CTRL_RST  = 8'h02;
  localparam logic [7:0] DUTY_RST  = 8'hff;
  localparam int         MAINT_SHIFT = 4;
  localparam int         REPORT_W    = 16;
  typedef enum logic [1:0] {BT_NICD, BT_NIMH, BT_LION} bcps_batt_t;
  typedef enum logic [3:0] {
    ST_CAP_DISCH, ST_MEASURE, ST_REPORT, ST_IDLE, ST_DISCHARGE,
    ST_NI_SOFT, ST_NI_FAST, ST_NI_TOP, ST_MAINT, ST_LI_QUAL,
    ST_LI_CC, ST_LI_CV, ST_DONE, ST_ERROR
  } bcps_state_t;
endpackage

// File: design/bcps_sync_if.sv
`timescale 1ns/1ns
`default_nettype none
interface bcps_sync_if;
  import bcps_pkg::*;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] clean;
  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface // bcps_sync_if
`default_nettype wire

// File: design/bcps_sync.sv
`timescale 1ns/1ns
`default_nettype none
module bcps_sync
  import bcps_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  bcps_sync_if.sync_side  sy
);
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic [SYNC_W-1:0] clean_r;

  // three stages; a bit changes once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      clean_r <= '0;
    end else begin
      s1_r <= sy.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < SYNC_W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          clean_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign sy.clean = clean_r;
endmodule // bcps_sync
`default_nettype wire

// File: design/bcps_top.sv
`timescale 1ns/1ns
`default_nettype none
module bcps_top
  import bcps_pkg::*;
#(
  parameter logic [31:0] MS_CYC        = 32'(MS_CYC_D),
  parameter logic [31:0] SLOW_TICK_CYC = 32'(SLOW_TICK_D)
) (
  input  wire logic                MCLK_IN,
  input  wire logic                RESET_IN,
  input  wire logic [SENSE_W-1:0]  SENSE_IN,
  input  wire logic [1:0]          DISCHARGE_MAINT_SELECT_IN,
  input  wire logic [1:0]          BATTERY_TYPE_SELECT_IN,
  input  wire logic                SUPPLY_OR_CELL_SELECT_IN,
  input  wire logic                TIMEOUT_RC_SELECT_IN,
  input  wire logic [1:0]          REG_ADDR_IN,
  input  wire logic [7:0]          REG_WDATA_IN,
  input  wire logic                REG_WR_IN,
  input  wire logic                REG_RD_IN,
  output logic [7:0]               REG_RDATA_OUT,
  output logic                     PHASE_INDICATOR_N_OUT,
  output logic                     CHARGE_DISCHARGE_INDICATOR_N_OUT,
  output logic                     START_STOP_ERROR_INDICATOR_N_OUT,
  output logic                     DISCHARGE_DRIVE_OUT,
  output logic                     SELF_MONITOR_OUT,
  output logic                     SELF_MONITOR_OE_N_OUT,
  output logic                     BUZZER_OUT,
  output logic                     CHARGE_CONTROL_OUT
);
  bcps_sync_if sy ();
  bcps_state_t  state_r;
  bcps_batt_t   batt_r;
  logic [1:0]   discharge_maint_select_r;
  logic         supply_or_cell_select_r;
  logic         fast_pwm_r;
  logic [7:0]   ctrl_r;
  logic [7:0]   duty_r;
  logic [31:0]  tick_cnt_r;
  logic         ms_tick;
  logic [31:0]  phase_ms_r;
  logic [31:0]  timeout_ms_r;
  logic [31:0]  meas_div_r;
  logic [11:0]  meas_cnt_r;
  logic [REPORT_W-1:0] report_r;
  logic [4:0]   report_bits_r;
  logic [31:0]  pwm_div_r;
  logic [7:0]   pwm_step_r;
  logic [7:0]   level;
  logic [31:0]  beep_ms_r;
  logic         err_temp_r;
  logic         illegal_r;
  logic [SENSE_W-1:0] sn;
  logic         restart_req;
  logic         is_charging;

  // input synchroniser for pins
  assign sy.raw = {TIMEOUT_RC_SELECT_IN, SUPPLY_OR_CELL_SELECT_IN, BATTERY_TYPE_SELECT_IN,
                   DISCHARGE_MAINT_SELECT_IN, SENSE_IN};
  assign sn     = sy.clean[SENSE_W-1:0];

  bcps_sync u_sync (
    .clk_in (MCLK_IN),
    .rst_in (RESET_IN),
    .sy     (sy.sync_side)
  );

  // current level as a fraction of the fast rate
  function automatic logic [7:0] fifth(input logic [7:0] d);
    logic [15:0] p;
    p = 16'(d) * 16'd51;
    return p[15:8];
  endfunction

  // millisecond time base
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r >= MS_CYC - 32'd1) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'd1;
    end
  end
  assign ms_tick = (tick_cnt_r >= MS_CYC - 32'd1);

  // register port: writes
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      ctrl_r <= CTRL_RST;
      duty_r <= DUTY_RST;
    end else begin
      ctrl_r[CTRL_RESTART] <= 1'b0; // restart is a one-cycle pulse
      if (REG_WR_IN && REG_ADDR_IN == REG_CTRL) begin
        ctrl_r <= REG_WDATA_IN;
      end
      if (REG_WR_IN && REG_ADDR_IN == REG_DUTY) begin
        duty_r <= REG_WDATA_IN;
      end
    end
  end
  assign restart_req = ctrl_r[CTRL_RESTART];

  // register port: read data one cycle after the strobe
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      REG_RDATA_OUT <= '0;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        REG_CTRL:   REG_RDATA_OUT <= ctrl_r;
        REG_DUTY:   REG_RDATA_OUT <= duty_r;
        REG_STATUS: REG_RDATA_OUT <= {err_temp_r, 3'h0, 4'(state_r)};
        default:    REG_RDATA_OUT <= {2'h0, fast_pwm_r, supply_or_cell_select_r, discharge_maint_select_r, 2'(batt_r)};
      endcase
    end else begin
      REG_RDATA_OUT <= '0;
    end
  end

  // charge sequencer, one state per phase
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      state_r      <= ST_CAP_DISCH;
      phase_ms_r   <= '0;
      err_temp_r   <= 1'b0;
      illegal_r    <= 1'b0;
    end else begin
      if (ms_tick) begin
        phase_ms_r <= phase_ms_r + 32'd1;
      end
      case (state_r)
        ST_CAP_DISCH: begin
          if (ms_tick && phase_ms_r >= CAP_DISCH_MS) begin
            state_r <= ST_MEASURE;
            phase_ms_r <= '0;
          end
        end
        ST_MEASURE: begin
          if (sy.clean[SY_TOP] || meas_cnt_r == MEAS_MAX) begin
            state_r <= ST_REPORT;
          end
        end
        ST_REPORT: begin
          if (ms_tick && report_bits_r == 5'd0) begin
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          phase_ms_r <= '0;
          if (sn[SN_PRESENT] && (!ctrl_r[CTRL_TEMPCHK] || sn[SN_TEMP_OK])) begin
            if (batt_r == BT_LION) begin
              state_r <= ST_LI_QUAL;
            end else if (discharge_maint_select_r == TRI_LOW) begin
              state_r <= ST_MAINT;
            end else if (discharge_maint_select_r == TRI_OPEN) begin
              state_r <= ST_DISCHARGE;
            end else begin
              state_r <= ST_NI_SOFT;
            end
          end
        end
        ST_DISCHARGE: begin
          if (!sn[SN_PRESENT]) begin
            state_r <= ST_IDLE;
          end else if (sn[SN_DISCHGD]) begin
            state_r <= ST_NI_SOFT;
            phase_ms_r <= '0;
          end
        end
        ST_NI_SOFT: begin
          if (sn[SN_NI_MAX]) begin
            state_r <= ST_ERROR;
          end else if (ms_tick && phase_ms_r >= SOFT_MS - 32'd1) begin
            state_r <= sn[SN_GOOD] ? ST_NI_FAST : ST_ERROR;
            phase_ms_r <= '0;
          end
        end
        ST_NI_FAST: begin
          if (sn[SN_TEMP_HOT]) begin
            state_r <= ST_ERROR;
            err_temp_r <= 1'b1;
          end else if (sn[SN_NI_MAX] || (ms_tick && phase_ms_r >= timeout_ms_r)) begin
            state_r <= ST_ERROR;
          end else if (batt_r == BT_NICD ? sn[SN_DROP_CD] : sn[SN_DROP_MH]) begin
            state_r <= ST_NI_TOP;
            phase_ms_r <= '0;
          end
        end
        ST_NI_TOP: begin
          if (ms_tick && phase_ms_r >= (timeout_ms_r >> TOP_SHIFT)) begin
            state_r <= ST_MAINT;
            phase_ms_r <= '0;
          end
        end
        ST_LI_QUAL: begin
          if (ms_tick && phase_ms_r >= QUAL_MS - 32'd1) begin
            state_r <= sn[SN_GOOD] ? ST_LI_CC : ST_ERROR;
            phase_ms_r <= '0;
          end
        end
        ST_LI_CC: begin
          if (supply_or_cell_select_r ? sn[SN_LI_42] : sn[SN_LI_41]) begin
            state_r <= ST_LI_CV;
            phase_ms_r <= '0;
          end else if (ms_tick && phase_ms_r >= timeout_ms_r) begin
            state_r <= ST_ERROR;
          end
        end
        ST_LI_CV: begin
          if (sn[SN_CS_LOW]) begin
            state_r <= (discharge_maint_select_r == TRI_OPEN) ? ST_DONE : ST_MAINT;
            phase_ms_r <= '0;
          end else if (ms_tick && phase_ms_r >= timeout_ms_r) begin
            state_r <= ST_ERROR;
          end
        end
        ST_MAINT, ST_DONE: begin
          if (!sn[SN_PRESENT]) begin
            state_r <= ST_IDLE;
          end else if (batt_r == BT_LION && discharge_maint_select_r != TRI_HIGH && sn[SN_RESTART]) begin
            state_r <= ST_LI_CC;
            phase_ms_r <= '0;
          end
        end
        ST_ERROR: begin
          if (!sn[SN_PRESENT] || (err_temp_r && sn[SN_TEMP_OK])) begin
            state_r <= ST_IDLE;
            err_temp_r <= 1'b0;
          end
        end
        default: begin
          illegal_r <= 1'b1;
        end
      endcase
      if (restart_req) begin
        state_r <= ST_IDLE;
      end
    end
  end

  // timeout capacitor measurement and configuration capture
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      meas_div_r   <= '0;
      meas_cnt_r   <= '0;
      batt_r       <= BT_NIMH;
      discharge_maint_select_r       <= TRI_HIGH;
      supply_or_cell_select_r       <= 1'b1;
      fast_pwm_r   <= 1'b1;
      timeout_ms_r <= TO_BASE_MS;
    end else if (state_r == ST_MEASURE) begin
      if (meas_div_r >= MEAS_TICK_CYC - 32'd1) begin
        meas_div_r <= '0;
        meas_cnt_r <= meas_cnt_r + 12'd1;
      end else begin
        meas_div_r <= meas_div_r + 32'd1;
      end
      if (sy.clean[SY_TOP] || meas_cnt_r == MEAS_MAX) begin
        timeout_ms_r <= TO_BASE_MS + 32'(meas_cnt_r) * TO_MS_PER_CNT;
        discharge_maint_select_r <= sy.clean[SY_DISCHARGE_MAINT_SELECT+:2];
        supply_or_cell_select_r <= sy.clean[SY_SUPPLY_OR_CELL_SELECT];
        case (sy.clean[SY_BATTERY_TYPE_SELECT+:2])
          TRI_HIGH: batt_r <= BT_NIMH;
          TRI_LOW:  batt_r <= BT_NICD;
          default:  batt_r <= BT_LION;
        endcase
        fast_pwm_r <= (sy.clean[SY_BATTERY_TYPE_SELECT+:2] == TRI_OPEN) || sy.clean[SY_SUPPLY_OR_CELL_SELECT];
      end
    end
  end

  // serial report shift register on the charge indicator
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      report_r      <= '0;
      report_bits_r <= '0;
    end else if (state_r == ST_MEASURE) begin
      report_r      <= {sy.clean[SY_DISCHARGE_MAINT_SELECT+:2], sy.clean[SY_BATTERY_TYPE_SELECT+:2], sy.clean[SY_SUPPLY_OR_CELL_SELECT], meas_cnt_r[10:0]};
      report_bits_r <= 5'(REPORT_W);
    end else if (state_r == ST_REPORT && ms_tick && report_bits_r != 5'd0) begin
      report_r      <= {report_r[REPORT_W-2:0], 1'b0};
      report_bits_r <= report_bits_r - 5'd1;
    end
  end

  // pwm step counter, fast or slow step rate
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      pwm_div_r  <= '0;
      pwm_step_r <= '0;
    end else if (pwm_div_r >= (fast_pwm_r ? FAST_TICK_CYC : SLOW_TICK_CYC) - 32'd1) begin
      pwm_div_r  <= '0;
      pwm_step_r <= pwm_step_r + 8'd1;
    end else begin
      pwm_div_r  <= pwm_div_r + 32'd1;
    end
  end

  // duty level per phase
  always_comb begin
    case (state_r)
      ST_NI_FAST, ST_LI_CC, ST_LI_CV: level = duty_r;
      ST_NI_SOFT, ST_NI_TOP, ST_LI_QUAL: level = fifth(duty_r);
      ST_MAINT: level = duty_r >> MAINT_SHIFT;
      default: level = 8'h00;
    endcase
  end
  assign is_charging = (level != 8'h00);

  // buzzer beep on start, finish and error
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      beep_ms_r <= '0;
    end else if ((state_r == ST_IDLE && sn[SN_PRESENT]) || (state_r == ST_ERROR && beep_ms_r == 32'd0 && !BUZZER_OUT)
                 || (state_r == ST_LI_CV && sn[SN_CS_LOW]) || (state_r == ST_NI_TOP && ms_tick
                 && phase_ms_r >= (timeout_ms_r >> TOP_SHIFT))) begin
      beep_ms_r <= BEEP_MS_W;
    end else if (ms_tick && beep_ms_r != 32'd0) begin
      beep_ms_r <= beep_ms_r - 32'd1;
    end
  end

  // registered pin outputs
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      PHASE_INDICATOR_N_OUT            <= 1'b1;
      CHARGE_DISCHARGE_INDICATOR_N_OUT <= 1'b1;
      START_STOP_ERROR_INDICATOR_N_OUT <= 1'b1;
      DISCHARGE_DRIVE_OUT              <= 1'b0;
      SELF_MONITOR_OUT                 <= 1'b0;
      SELF_MONITOR_OE_N_OUT            <= 1'b1;
      BUZZER_OUT                       <= 1'b0;
      CHARGE_CONTROL_OUT               <= 1'b0;
    end else begin
      // low while the timeout capacitor is held discharged, then phase display
      PHASE_INDICATOR_N_OUT <= !((state_r == ST_CAP_DISCH) || state_r == ST_NI_FAST
                                 || state_r == ST_LI_CC || state_r == ST_LI_CV
                                 || ((state_r == ST_NI_TOP || state_r == ST_MAINT)
                                     && phase_ms_r[9]));
      CHARGE_DISCHARGE_INDICATOR_N_OUT <= (state_r == ST_REPORT) ? !report_r[REPORT_W-1]
                                        : !(is_charging || state_r == ST_DISCHARGE);
      START_STOP_ERROR_INDICATOR_N_OUT <= !(state_r == ST_ERROR || state_r == ST_DONE
                                           || state_r == ST_NI_SOFT || state_r == ST_LI_QUAL);
      DISCHARGE_DRIVE_OUT   <= (state_r == ST_DISCHARGE);
      SELF_MONITOR_OUT      <= 1'b0;
      SELF_MONITOR_OE_N_OUT <= !illegal_r;
      BUZZER_OUT            <= (beep_ms_r != 32'd0);
      CHARGE_CONTROL_OUT    <= is_charging && (pwm_step_r < level || level == 8'hff);
    end
  end
endmodule // bcps_top
`default_nettype wire

// File: test/bcps_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module bcps_top_checker
  import bcps_pkg::*;
#(
  parameter logic [31:0] MS_CYC = 32'd10
) (
  input wire logic               MCLK_IN,
  input wire logic               RESET_IN,
  input wire logic [SENSE_W-1:0] SENSE_IN,
  input wire logic [1:0]         REG_ADDR_IN,
  input wire logic               REG_RD_IN,
  input wire logic [7:0]         REG_RDATA_OUT,
  input wire logic               PHASE_INDICATOR_N_OUT,
  input wire logic               CHARGE_DISCHARGE_INDICATOR_N_OUT,
  input wire logic               START_STOP_ERROR_INDICATOR_N_OUT,
  input wire logic               DISCHARGE_DRIVE_OUT,
  input wire logic               SELF_MONITOR_OUT,
  input wire logic               SELF_MONITOR_OE_N_OUT,
  input wire logic               BUZZER_OUT,
  input wire logic               CHARGE_CONTROL_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  logic [31:0] beep_cnt_r;
  // length of the current buzzer burst
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN || !BUZZER_OUT) beep_cnt_r <= 32'h0;
    else beep_cnt_r <= beep_cnt_r + 32'h1;
  end
  property p_rst_vals;
    $fell(RESET_IN) |-> PHASE_INDICATOR_N_OUT && CHARGE_DISCHARGE_INDICATOR_N_OUT && START_STOP_ERROR_INDICATOR_N_OUT
      && !DISCHARGE_DRIVE_OUT && SELF_MONITOR_OE_N_OUT && !BUZZER_OUT && !CHARGE_CONTROL_OUT && REG_RDATA_OUT == 8'h0;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("outputs not at reset level");
  property p_cap_led;
    $fell(RESET_IN) |=> !PHASE_INDICATOR_N_OUT [*4];
  endproperty
  a_cap_led: assert property (p_cap_led) else $error("phase indicator not discharging capacitor");
  property p_rdata_idle;
    !$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  property p_status_fmt;
    REG_RD_IN && REG_ADDR_IN == REG_STATUS |=> REG_RDATA_OUT[6:4] == 3'h0 && REG_RDATA_OUT[3:0] <= 4'hd;
  endproperty
  a_status_fmt: assert property (p_status_fmt) else $error("state code out of range");
  property p_mon_low;
    SELF_MONITOR_OUT == 1'b0;
  endproperty
  a_mon_low: assert property (p_mon_low) else $error("monitor pin driven high");
  property p_beep_len;
    $fell(BUZZER_OUT) |-> beep_cnt_r >= BEEP_MS_W * MS_CYC;
  endproperty
  a_beep_len: assert property (p_beep_len) else $error("buzzer burst too short");
  property p_no_chg_disch;
    DISCHARGE_DRIVE_OUT |-> !CHARGE_CONTROL_OUT;
  endproperty
  a_no_chg_disch: assert property (p_no_chg_disch) else $error("charging while discharging");
  property p_disch_end;
    $rose(SENSE_IN[SN_DISCHGD]) && DISCHARGE_DRIVE_OUT |-> ##[1:10] !DISCHARGE_DRIVE_OUT;
  endproperty
  a_disch_end: assert property (p_disch_end) else $error("discharge drive stuck after end");
endmodule // bcps_top_checker
bind bcps_top bcps_top_checker #(.MS_CYC(MS_CYC)) i_chk (.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN),
  .SENSE_IN(SENSE_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .PHASE_INDICATOR_N_OUT(PHASE_INDICATOR_N_OUT), .CHARGE_DISCHARGE_INDICATOR_N_OUT(CHARGE_DISCHARGE_INDICATOR_N_OUT),
  .START_STOP_ERROR_INDICATOR_N_OUT(START_STOP_ERROR_INDICATOR_N_OUT), .DISCHARGE_DRIVE_OUT(DISCHARGE_DRIVE_OUT),
  .SELF_MONITOR_OUT(SELF_MONITOR_OUT), .SELF_MONITOR_OE_N_OUT(SELF_MONITOR_OE_N_OUT), .BUZZER_OUT(BUZZER_OUT),
  .CHARGE_CONTROL_OUT(CHARGE_CONTROL_OUT));
`default_nettype wire

// File: test/bcps_charger_env.sv
`timescale 1ns/1ns
`default_nettype none
module bcps_charger_env
  import bcps_pkg::*;
#(
  parameter int DIS_CYC = 40
) (
  input  wire logic               clk_in,
  input  wire logic               rst_req_in,
  input  wire logic [SENSE_W-1:0] sense_req_in,
  input  wire logic               disch_drive_in,
  input  wire logic               mon_oe_n_in,
  output logic [SENSE_W-1:0]      sense_out,
  output logic                    rst_out
);
  int unsigned dis_cnt_r;
  // pack runs flat a fixed time after the discharge fet closes
  always_ff @(posedge clk_in) begin
    if (!disch_drive_in) dis_cnt_r <= 0;
    else if (dis_cnt_r < DIS_CYC) dis_cnt_r <= dis_cnt_r + 1;
  end
  // comparator levels seen by the device
  always_comb begin
    sense_out = sense_req_in;
    sense_out[SN_DISCHGD] = (dis_cnt_r == DIS_CYC);
  end
  // monitor pin pulls the reset line on the board
  assign rst_out = rst_req_in | ~mon_oe_n_in;
endmodule // bcps_charger_env
`default_nettype wire

// File: test/bcps_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module bcps_top_tb_top
  import bcps_pkg::*;
;
  logic clk, rst_req, rst, supply_or_cell_select, to_sel, wr, rd, ph_n, cd_n, sse_n, dis, mon, mon_oe_n, buz, ctl;
  logic [1:0] discharge_maint_select, battery_type_select, addr;
  logic [7:0] wdata, rdata, d;
  logic [SENSE_W-1:0] sense_req, sense;
  int n_errors, num_checks, k;
  logic [1:0] n_discharge_maint_select [3] = '{2'h1, 2'h0, 2'h2};
  logic [1:0] n_batt [3] = '{2'h0, 2'h1, 2'h0};
  logic [3:0] n_first [3] = '{4'h5, 4'h8, 4'h4};
  logic [7:0] n_cfg [3] = '{8'h04, 8'h01, 8'h08};
  bcps_charger_env i_env (.clk_in(clk), .rst_req_in(rst_req), .sense_req_in(sense_req), .disch_drive_in(dis),
    .mon_oe_n_in(mon_oe_n), .sense_out(sense), .rst_out(rst));
  bcps_top #(.MS_CYC(32'd1), .SLOW_TICK_CYC(32'd4)) i_dut (.MCLK_IN(clk), .RESET_IN(rst), .SENSE_IN(sense),
    .DISCHARGE_MAINT_SELECT_IN(discharge_maint_select), .BATTERY_TYPE_SELECT_IN(battery_type_select), .SUPPLY_OR_CELL_SELECT_IN(supply_or_cell_select),
    .TIMEOUT_RC_SELECT_IN(to_sel), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .PHASE_INDICATOR_N_OUT(ph_n), .CHARGE_DISCHARGE_INDICATOR_N_OUT(cd_n),
    .START_STOP_ERROR_INDICATOR_N_OUT(sse_n), .DISCHARGE_DRIVE_OUT(dis), .SELF_MONITOR_OUT(mon),
    .SELF_MONITOR_OE_N_OUT(mon_oe_n), .BUZZER_OUT(buz), .CHARGE_CONTROL_OUT(ctl));
  // 10 mhz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // single cycle register write
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read strobe, data stand in the following cycle and are taken mid-cycle
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  // poll the state code under a bound
  task automatic wait_st(input logic [3:0] exp, input int bound);
    logic [7:0] s;
    for (int i = 0; i < bound; i++) begin
      rd_reg(REG_STATUS, s);
      if (s[3:0] === exp) return;
    end
    n_errors++;
    $display("mismatch at %0t: state %h never reached", $time, exp);
    stop_test();
  endtask
  // new charge cycle with the given strap levels
  task automatic do_reset(input logic [1:0] s1, input logic [1:0] s2, input logic s3);
    discharge_maint_select <= s1;
    battery_type_select <= s2;
    supply_or_cell_select <= s3;
    rst_req <= 1'b1;
    repeat (16) @(posedge clk);
    rst_req <= 1'b0;
  endtask
  // main sequence
  initial begin
    rst_req = 1'b1;
    discharge_maint_select = 2'h1;
    battery_type_select = 2'h2;
    supply_or_cell_select = 1'b1;
    to_sel = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 8'h0;
    sense_req = '0;
    sense_req[SN_PRESENT] = 1'b1;
    sense_req[SN_TEMP_OK] = 1'b1;
    n_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({5'h0, dis, buz, mon_oe_n}, 8'h01);
    repeat (8) @(posedge clk);
    rst_req <= 1'b0;
    rd_reg(REG_CTRL, d);
    chk(d, CTRL_RST);
    rd_reg(REG_DUTY, d);
    chk(d, DUTY_RST);
    wr_reg(REG_CONFIG, 8'h00);
    wait_st(4'h9, 2000);
    rd_reg(REG_CONFIG, d);
    chk(d, 8'h36);
    discharge_maint_select <= 2'h2;
    battery_type_select <= 2'h0;
    supply_or_cell_select <= 1'b0;
    repeat (10) @(posedge clk);
    rd_reg(REG_CONFIG, d);
    chk(d, 8'h36);
    sense_req[SN_GOOD] <= 1'b1;
    wait_st(4'ha, 40000);
    sense_req[SN_LI_41] <= 1'b1;
    repeat (20) @(posedge clk);
    rd_reg(REG_STATUS, d);
    chk({4'h0, d[3:0]}, 8'h0a);
    @(negedge clk);
    chk({7'h0, cd_n}, 8'h00);
    chk({7'h0, ctl}, 8'h01);
    @(posedge clk);
    sense_req[SN_LI_42] <= 1'b1;
    wait_st(4'hb, 50);
    sense_req[SN_CS_LOW] <= 1'b1;
    wait_st(4'h8, 50);
    rd_reg(REG_STATUS, d);
    chk({4'h0, d[3:0]}, 8'h08);
    $display("lithium test done");
    sense_req <= 12'h201;
    for (k = 0; k < 3; k++) begin
      do_reset(n_discharge_maint_select[k], n_batt[k], 1'b0);
      wait_st(n_first[k], 2000);
      rd_reg(REG_CONFIG, d);
      chk(d, n_cfg[k]);
    end
    @(negedge clk);
    chk({7'h0, dis}, 8'h01);
    @(posedge clk);
    wait_st(4'h5, 200);
    @(negedge clk);
    chk({7'h0, dis}, 8'h00);
    @(posedge clk);
    sense_req[SN_NI_MAX] <= 1'b1;
    wait_st(4'hd, 50);
    sense_req[SN_NI_MAX] <= 1'b0;
    repeat (20) @(posedge clk);
    rd_reg(REG_STATUS, d);
    chk({4'h0, d[3:0]}, 8'h0d);
    @(negedge clk);
    chk({7'h0, sse_n}, 8'h00);
    @(posedge clk);
    sense_req[SN_PRESENT] <= 1'b0;
    wait_st(4'h3, 50);
    $display("nickel test done");
    stop_test();
  end
endmodule // bcps_top_tb_top
`default_nettype wire
